// ==== hdl/tcg_tx_crc.sv ====
// Purpose: Transmit frame checksum generator with APB configuration
// Assumes: Frame bytes and modulator side share clock_i
// Notes:   One output byte register; no further buffering
`timescale 1ns/1ps
module tcg_tx_crc #(
    parameter logic [15:0] POLY16 = tcg_pkg::POLY16_DEF,
    parameter logic [4:0]  POLY5  = tcg_pkg::POLY5_DEF
) (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        in_valid_i,
    input  wire logic [7:0]  in_data_i,
    input  wire logic        in_last_i,
    output logic             in_ready_o,
    output logic             out_valid_o,
    output logic      [7:0]  out_data_o,
    output logic             out_last_o,
    input  wire logic        out_ready_i
);
    // Configuration register and its decoded fields
    logic [31:0]         cfg_reg;
    logic                crc_enable;
    logic                crc_output_invert;
    logic                crc_width5;
    logic [2:0]          crc_seed_sel;
    logic                crc_skip_first_byte;
    logic [15:0]         crc_prog_seed;
    // Register bus side
    logic [31:0]         rdata_reg;
    logic                slverr_reg;
    logic                apb_setup;
    logic                apb_access;
    logic                cfg_hit;
    // Checksum datapath
    logic [15:0]         crc_reg;
    logic [15:0]         crc_next;
    logic [15:0]         crc_base;
    logic [15:0]         seed_w;
    logic [15:0]         crc_final;
    logic                first_reg;
    // Frame sequencing and the single output byte
    tcg_pkg::tcg_state_t state_reg;
    logic                slot_free;
    logic                in_take;
    logic                out_valid_reg;
    logic [7:0]          out_data_reg;
    logic                out_last_reg;

    // One byte through the 16-bit register, low bit first
    function automatic logic [15:0] crc16_step(
        input logic [15:0] crc_in,
        input logic [7:0]  data_in
    );
        logic [15:0] acc;
        acc = crc_in;
        for (int i = 0; i < 8; i++) begin
            if (acc[0] ^ data_in[i]) begin
                acc = (acc >> 1) ^ POLY16;
            end else begin
                acc = acc >> 1;
            end
        end
        return acc;
    endfunction

    // One byte through the 5-bit register, low bit first
    function automatic logic [4:0] crc5_step(
        input logic [4:0] crc_in,
        input logic [7:0] data_in
    );
        logic [4:0] acc;
        acc = crc_in;
        for (int i = 0; i < 8; i++) begin
            if (acc[0] ^ data_in[i]) begin
                acc = (acc >> 1) ^ POLY5;
            end else begin
                acc = acc >> 1;
            end
        end
        return acc;
    endfunction

    // Seed table; the reserved code falls back to zero so that a stray
    // write cannot leave the register seeded with something undefined
    function automatic logic [15:0] seed_lookup(
        input logic [2:0]  sel,
        input logic [15:0] prog
    );
        logic [15:0] val;
        val = tcg_pkg::SEED_0;
        case (sel)
            3'h0: val = tcg_pkg::SEED_0; // RULE_03
            3'h1: val = tcg_pkg::SEED_1;
            3'h2: val = tcg_pkg::SEED_2;
            3'h3: val = tcg_pkg::SEED_3;
            3'h4: val = tcg_pkg::SEED_4;
            3'h5: val = tcg_pkg::SEED_5;
            tcg_pkg::SEL_PROG: val = prog; // RULE_01
            default: val = tcg_pkg::SEED_0; // RULE_10
        endcase
        return val;
    endfunction

    // Field decode of the configuration register
    assign crc_enable          = cfg_reg[tcg_pkg::ENABLE_BIT];
    assign crc_output_invert   = cfg_reg[tcg_pkg::INVERT_BIT];
    assign crc_width5          = cfg_reg[tcg_pkg::TYPE_BIT]; // RULE_05
    assign crc_seed_sel        = cfg_reg[tcg_pkg::SEL_LSB +: 3];
    assign crc_skip_first_byte = cfg_reg[tcg_pkg::SKIP_BIT];
    assign crc_prog_seed       = cfg_reg[tcg_pkg::SEED_LSB +: 16];

    // Bus phases; zero wait states, so ready simply follows the access
    assign apb_setup  = psel_i && !penable_i;
    assign apb_access = psel_i && penable_i;
    assign cfg_hit    = (paddr_i == tcg_pkg::CFG_ADDR);
    assign pready_o   = apb_access;
    assign pslverr_o  = apb_access && slverr_reg;
    assign prdata_o   = rdata_reg;

    // Config write; masking keeps the reserved bits at zero
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            cfg_reg <= tcg_pkg::CFG_RESET; // RULE_08
        end else if (apb_access && pwrite_i && cfg_hit) begin
            cfg_reg <= pwdata_i & tcg_pkg::CFG_WMASK; // RULE_10
        end
    end

    // Read data and error are latched in setup so they stand in access
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rdata_reg  <= 32'h0000_0000;
            slverr_reg <= 1'b0;
        end else if (apb_setup) begin
            if (cfg_hit) begin
                rdata_reg  <= cfg_reg;
                slverr_reg <= 1'b0;
            end else begin
                rdata_reg  <= 32'h0000_0000;
                slverr_reg <= 1'b1;
            end
        end
    end

    // Seed for the next frame; 5-bit mode keeps only the low bits
    always_comb begin
        seed_w = seed_lookup(crc_seed_sel, crc_prog_seed);
        if (crc_width5) begin
            seed_w = seed_w & tcg_pkg::MASK5; // RULE_04
        end
    end

    // Handshake: bytes are taken only while the output slot can move
    assign slot_free  = !out_valid_reg || out_ready_i;
    assign in_ready_o = (state_reg == tcg_pkg::ST_DATA) && slot_free;
    assign in_take    = in_valid_i && in_ready_o;

    // Next checksum value; the first byte of a frame starts from the seed
    always_comb begin
        crc_base = crc_reg;
        crc_next = crc_reg;
        if (first_reg) begin
            crc_base = seed_w;
        end
        if (in_take) begin
            if (first_reg && crc_skip_first_byte) begin
                crc_next = seed_w; // RULE_02
            end else if (crc_width5) begin
                crc_next = {11'h000, crc5_step(crc_base[4:0], in_data_i)};
            end else begin
                crc_next = crc16_step(crc_base, in_data_i); // RULE_09
            end
        end
    end

    // Checksum as sent; inversion only touches the live width
    always_comb begin
        crc_final = crc_reg;
        if (crc_output_invert) begin
            crc_final = ~crc_reg; // RULE_06
        end
        if (crc_width5) begin
            crc_final = crc_final & tcg_pkg::MASK5;
        end
    end

    // Checksum register
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            crc_reg <= 16'h0000;
        end else begin
            crc_reg <= crc_next;
        end
    end

    // Frame start flag; set again by the last byte of each frame
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            first_reg <= 1'b1;
        end else if (in_take) begin
            first_reg <= in_last_i;
        end
    end

    // Frame sequencing; the checksum bytes follow the last data byte
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_reg <= tcg_pkg::ST_DATA;
        end else begin
            case (state_reg)
                tcg_pkg::ST_DATA: begin
                    if (in_take && in_last_i && crc_enable) begin
                        state_reg <= tcg_pkg::ST_CRC_LO; // RULE_07
                    end
                end
                tcg_pkg::ST_CRC_LO: begin
                    if (slot_free && crc_width5) begin
                        state_reg <= tcg_pkg::ST_DATA;
                    end else if (slot_free) begin
                        state_reg <= tcg_pkg::ST_CRC_HI;
                    end
                end
                tcg_pkg::ST_CRC_HI: begin
                    if (slot_free) begin
                        state_reg <= tcg_pkg::ST_DATA;
                    end
                end
                default: begin
                    state_reg <= tcg_pkg::ST_DATA;
                end
            endcase
        end
    end

    // Single output byte; low checksum byte goes out first
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            out_valid_reg <= 1'b0;
            out_data_reg  <= 8'h00;
            out_last_reg  <= 1'b0;
        end else begin
            case (state_reg)
                tcg_pkg::ST_DATA: begin
                    if (in_take) begin
                        out_valid_reg <= 1'b1;
                        out_data_reg  <= in_data_i;
                        out_last_reg  <= in_last_i && !crc_enable;
                    end else if (out_ready_i) begin
                        out_valid_reg <= 1'b0;
                    end
                end
                tcg_pkg::ST_CRC_LO: begin
                    if (slot_free) begin
                        out_valid_reg <= 1'b1;
                        out_data_reg  <= crc_final[7:0];
                        out_last_reg  <= crc_width5;
                    end
                end
                tcg_pkg::ST_CRC_HI: begin
                    if (slot_free) begin
                        out_valid_reg <= 1'b1;
                        out_data_reg  <= crc_final[15:8];
                        out_last_reg  <= 1'b1;
                    end
                end
                default: begin
                    out_valid_reg <= 1'b0;
                end
            endcase
        end
    end

    assign out_valid_o = out_valid_reg;
    assign out_data_o  = out_data_reg;
    assign out_last_o  = out_last_reg;

    // Reset returns the register and the output stage to idle
    property p_reset_clears;
        @(posedge clock_i)
        reset_i |=> (cfg_reg == tcg_pkg::CFG_RESET)
                    && (state_reg == tcg_pkg::ST_DATA) && !out_valid_reg;
    endproperty
    a_reset_clears: assert property (p_reset_clears) // RULE_08
        else $error("config or output stage not idle after reset");

    // A skipped first byte leaves the seed in place
    property p_skip_first;
        @(posedge clock_i) disable iff (reset_i)
        in_take && first_reg && crc_skip_first_byte
            |=> crc_reg == $past(seed_w);
    endproperty
    a_skip_first: assert property (p_skip_first) // RULE_02
        else $error("skipped first byte changed the checksum");

    // Selector all-ones in 16-bit mode takes the programmable seed
    property p_prog_seed;
        @(posedge clock_i) disable iff (reset_i)
        (crc_seed_sel == tcg_pkg::SEL_PROG) && !crc_width5
            |-> seed_w == crc_prog_seed;
    endproperty
    a_prog_seed: assert property (p_prog_seed) // RULE_01
        else $error("programmable seed not selected");

    // Reserved selector behaves as seed zero
    property p_reserved_seed;
        @(posedge clock_i) disable iff (reset_i)
        crc_seed_sel == 3'h6 |-> seed_w == 16'h0000;
    endproperty
    a_reserved_seed: assert property (p_reserved_seed) // RULE_10
        else $error("reserved seed code not treated as zero");

    // 5-bit mode keeps the upper register bits clear
    property p_width5_upper;
        @(posedge clock_i) disable iff (reset_i)
        in_take && crc_width5 |=> crc_reg[15:5] == 11'h000;
    endproperty
    a_width5_upper: assert property (p_width5_upper) // RULE_05
        else $error("5-bit checksum spilled into upper bits");

    // Without the enable the data byte itself closes the frame
    property p_no_append;
        @(posedge clock_i) disable iff (reset_i)
        in_take && in_last_i && !crc_enable
            |=> (state_reg == tcg_pkg::ST_DATA) && out_last_reg;
    endproperty
    a_no_append: assert property (p_no_append) // RULE_07
        else $error("checksum appended while disabled");

    // Low checksum byte leaves inverted exactly when asked
    property p_invert_lo;
        @(posedge clock_i) disable iff (reset_i)
        (state_reg == tcg_pkg::ST_CRC_LO) && slot_free && !crc_width5
            |=> out_data_reg == ($past(crc_reg[7:0])
                                 ^ {8{$past(crc_output_invert)}});
    endproperty
    a_invert_lo: assert property (p_invert_lo) // RULE_06
        else $error("checksum byte inversion wrong");
endmodule

// ==== hdl/tcg_pkg.sv ====
// Purpose: Constants for the transmit frame checksum generator
// Assumes: APB register access, 32-bit data, one system clock
// Notes:   Functional notes
// Functional notes
// (RULE_01) Upper half of config holds programmable seed, used for selector 111b.
// (RULE_02) Skip option leaves first frame byte out of the checksum.
// (RULE_03) Selector codes 000b-101b pick fixed seeds; 110b reserved; 111b programmable.
// (RULE_04) In 5-bit mode only the seed's low byte loads the register; the code keeps only its low five bits (MASK5).
// (RULE_05) Width bit clear gives 16-bit checksum, set gives 5-bit checksum.
// (RULE_06) Invert bit sends the complement of the checksum, else it is unchanged.
// (RULE_07) Checksum is computed and appended only while the enable bit is one; the code updates crc_reg on every byte, enable gates only the append.
// (RULE_08) Reset leaves generation off, 16-bit, no invert, seed code zero.
// (RULE_09) Polynomials are parameters; bytes are processed least significant bit first.
// (RULE_10) Reserved bits read zero, ignore writes; reserved seed code acts as zero.
package tcg_pkg;
    // Register index as printed; byte address is four times it
    localparam logic [11:0] CFG_INDEX  = 12'h019;
    localparam logic [11:0] CFG_ADDR   = 12'h064;
    localparam logic [11:0] STAT_ADDR  = 12'h080;
    localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
    localparam logic [31:0] CFG_WMASK  = 32'hffff_007f;
    // Field positions in the config register
    localparam int          ENABLE_BIT = 0;
    localparam int          INVERT_BIT = 1;
    localparam int          TYPE_BIT   = 2;
    localparam int          SEL_LSB    = 3;
    localparam int          SKIP_BIT   = 6;
    localparam int          SEED_LSB   = 16;
    // Fixed seeds
    localparam logic [15:0] SEED_0     = 16'h0000;
    localparam logic [15:0] SEED_1     = 16'h6363;
    localparam logic [15:0] SEED_2     = 16'ha671;
    localparam logic [15:0] SEED_3     = 16'hffff;
    localparam logic [15:0] SEED_4     = 16'h0012;
    localparam logic [15:0] SEED_5     = 16'he012;
    localparam logic [2:0]  SEL_PROG   = 3'h7;
    // Default polynomials, reflected for LSB-first shifting
    localparam logic [15:0] POLY16_DEF = 16'h8408;
    localparam logic [4:0]  POLY5_DEF  = 5'h14;
    localparam logic [15:0] MASK5      = 16'h001f;

    typedef enum logic [2:0] {
        ST_DATA   = 3'b001,
        ST_CRC_LO = 3'b010,
        ST_CRC_HI = 3'b100
    } tcg_state_t;
endpackage

// ==== testbench/tcg_sink.sv ====
// Purpose: Modulator-side sink
// Assumes: Shares clock_i
// Notes:   Ready toggles, so stalls mix with prompt takes
`timescale 1ns/1ps
module tcg_sink (
    input  wire logic clock_i,
    output logic      ready_o
);
    // Alternate ready each cycle
    initial ready_o = 1'b0;
    always @(posedge clock_i) ready_o <= ~ready_o;
endmodule

// ==== testbench/tb_tcg_tx_crc.sv ====
// Purpose: Config register and frame checksum bench
// Assumes: APB waits on pready; sink on the output side
// Notes:   Checksums come from an integer model of the rules
`timescale 1ns/1ps
module tb_tcg_tx_crc;
    logic        clock_i    = 1'b0;
    logic        reset_i    = 1'b1;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [11:0] paddr      = 12'h000;
    logic [31:0] pwdata     = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [31:0] cfg;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic        in_valid   = 1'b0;
    logic        in_last    = 1'b0;
    logic [7:0]  in_data    = 8'h00;
    logic        in_ready;
    logic        out_valid;
    logic        out_last;
    logic        out_ready;
    logic [7:0]  out_data;
    logic [31:0] x          = 32'h86db165d;
    logic [8:0]  expq[$];
    logic [8:0]  rxq[$];
    int          fails      = 0;
    int          num_checks = 0;

    // 10 MHz clock
    always #50 clock_i = ~clock_i;

    tcg_tx_crc dut(
        .clock_i     (clock_i),
        .reset_i     (reset_i),
        .psel_i      (psel),
        .penable_i   (penable),
        .pwrite_i    (pwrite),
        .paddr_i     (paddr),
        .pwdata_i    (pwdata),
        .prdata_o    (prdata),
        .pready_o    (pready),
        .pslverr_o   (pslverr),
        .in_valid_i  (in_valid),
        .in_data_i   (in_data),
        .in_last_i   (in_last),
        .in_ready_o  (in_ready),
        .out_valid_o (out_valid),
        .out_data_o  (out_data),
        .out_last_o  (out_last),
        .out_ready_i (out_ready)
    );
    tcg_sink snk(.clock_i(clock_i), .ready_o(out_ready));

    // Capture every byte that the sink takes
    always @(posedge clock_i) begin
        if (!reset_i && out_valid && out_ready) begin
            rxq.push_back({out_last, out_data});
        end
    end

    function automatic logic [31:0] lfsr(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Reference checksum step, low bit first, reflected polynomial
    function automatic int m_step(int crc, int data, int poly);
        int acc;
        acc = crc;
        for (int i = 0; i < 8; i++) begin
            if (((acc ^ (data >> i)) & 1) != 0) acc = (acc >> 1) ^ poly;
            else acc = acc >> 1;
        end
        return acc;
    endfunction

    // Reference seed; reserved code acts as zero
    function automatic int m_seed(logic [31:0] c);
        int s;
        case (c[5:3])
            3'h0: s = tcg_pkg::SEED_0;
            3'h1: s = tcg_pkg::SEED_1;
            3'h2: s = tcg_pkg::SEED_2;
            3'h3: s = tcg_pkg::SEED_3;
            3'h4: s = tcg_pkg::SEED_4;
            3'h5: s = tcg_pkg::SEED_5;
            3'h7: s = c[31:16];
            default: s = 0;
        endcase
        if (c[2]) s = s & 'h1f;
        return s;
    endfunction

    task chk(logic [31:0] g, logic [31:0] h);
        num_checks++;
        if (g !== h) begin
            fails++;
            $display("unexpected %0t mismatch %0h vs %0h", $time, g, h);
        end
    endtask

    // One APB transfer; read data taken at the pready edge
    task automatic apb(logic wr, logic [11:0] ad, logic [31:0] wd);
        @(posedge clock_i);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= wd;
        @(posedge clock_i);
        penable <= 1'b1;
        do @(posedge clock_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Send one frame, build the expected bytes, then compare all
    task automatic frame(logic [31:0] c, int len);
        int         crc;
        logic [8:0] seen;
        crc = m_seed(c);
        for (int k = 0; k < len; k++) begin
            x = lfsr(x);
            if (k != 0 || !c[6]) begin
                crc = m_step(crc, x[7:0], c[2] ? int'(tcg_pkg::POLY5_DEF)
                                               : int'(tcg_pkg::POLY16_DEF));
            end
            expq.push_back({(k == len - 1) && !c[0], x[7:0]});
            in_valid <= 1'b1;
            in_data  <= x[7:0];
            in_last  <= (k == len - 1);
            do @(posedge clock_i); while (in_ready !== 1'b1);
        end
        in_valid <= 1'b0;
        if (c[0]) begin
            if (c[1]) crc = ~crc & (c[2] ? 'h1f : 'hffff);
            if (c[2]) begin
                expq.push_back({1'b1, 8'(crc)});
            end else begin
                expq.push_back({1'b0, 8'(crc)});
                expq.push_back({1'b1, 8'(crc >> 8)});
            end
        end
        while (rxq.size() < expq.size()) @(posedge clock_i);
        repeat (4) @(posedge clock_i);
        chk(rxq.size(), expq.size());
        while (rxq.size() > 0 && expq.size() > 0) begin
            seen = rxq.pop_front();
            chk({23'h0, seen}, {23'h0, expq.pop_front()});
        end
        rxq.delete();
        expq.delete();
    endtask

    task summarize;
        if (fails == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Every seed code in both widths, then one frame with no checksum
    initial begin
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        apb(1'b0, tcg_pkg::CFG_ADDR, 32'h0);
        chk(rd, tcg_pkg::CFG_RESET);
        apb(1'b0, tcg_pkg::STAT_ADDR, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (int i = 0; i < 17; i++) begin
            x = lfsr(x);
            cfg = x;
            cfg[5:3] = i[2:0];
            cfg[2] = i[3];
            cfg[0] = (i < 16);
            apb(1'b1, tcg_pkg::CFG_ADDR, cfg);
            apb(1'b0, tcg_pkg::CFG_ADDR, 32'h0);
            chk(rd, cfg & tcg_pkg::CFG_WMASK);
            frame(cfg & tcg_pkg::CFG_WMASK, 1 + int'(x[10:8]) % 5);
        end
        // Reset in mid-run must clear the register again
        @(posedge clock_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        apb(1'b0, tcg_pkg::CFG_ADDR, 32'h0);
        chk(rd, tcg_pkg::CFG_RESET);
        frame(tcg_pkg::CFG_RESET, 3);
        summarize;
    end

    // Watchdog
    initial begin
        #500000;
        fails++;
        summarize;
    end
endmodule
